// >>> dadc_capture_model.sv
// Capture logic at the far side of the two result buses.
// Assumes the converter block's buses and per-bit enables, one clock.
`default_nettype none

module dadc_capture_model
  import dadc_pkg::*;
(
  // Clock
  input  wire logic                    clock,
  // Result buses and their enables, low while driven
  input  wire logic [dadc_pkg::DW-1:0] bus_a,
  input  wire logic [dadc_pkg::DW-1:0] oe_a_n,
  input  wire logic [dadc_pkg::DW-1:0] bus_b,
  input  wire logic [dadc_pkg::DW-1:0] oe_b_n,
  // Words latched from the wires
  output logic      [dadc_pkg::DW-1:0] cap_a,
  output logic      [dadc_pkg::DW-1:0] cap_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] wire_a;
  logic [DW-1:0] wire_b;

  // No pull on the lines: a floating bit reads as the inverse of the last
  assign wire_a = (bus_a & ~oe_a_n) | (~cap_a & oe_a_n);
  assign wire_b = (bus_b & ~oe_b_n) | (~cap_b & oe_b_n);

  // Both words latched together on the rising edge
  always_ff @(posedge clock) begin
    cap_a <= wire_a;
    cap_b <= wire_b;
  end
endmodule

`default_nettype wire

// >>> dadc_fifo.sv
// Shared constants and carriers of the dual converter output block, and
// the capture FIFO that buffers result pairs for software.
// Assumes one clock and a synchronous active-low reset throughout.
`default_nettype none

package dadc_pkg;
  // Data and bus widths
  localparam int DW         = 8;
  localparam int AW         = 12;
  localparam int BW         = 32;
  // Conversion pipeline: seven half-cycle stages plus the output latch
  localparam int HALF_STG   = 7;
  localparam int LAT        = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 2 * DW;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL   = 12'h000;
  localparam logic [AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [AW-1:0] OFS_DATA   = 12'h008;
  localparam logic [AW-1:0] OFS_COUNT  = 12'h00c;
  // Control register fields
  localparam int CTRL_TWOS  = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_PD    = 2;
  localparam int CTRL_OFF   = 3;
  localparam int CTRL_CAP   = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Status register fields
  localparam int ST_TWOS  = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_PD    = 2;
  localparam int ST_DRIVE = 3;
  localparam int ST_EMPTY = 4;
  localparam int ST_FULL  = 5;
  localparam int ST_OVF   = 6;
  localparam int ST_LVL   = 8;
  // Data register valid flag
  localparam int DATA_VLD = 16;

  // Control levels, from the pins
  typedef struct packed {
    logic twos;
    logic sleep;
    logic pd;
    logic out_n;
  } dadc_ctrl_s;

  // One sample pair travelling down the pipeline
  typedef struct packed {
    logic          vld;
    logic [DW-1:0] a;
    logic [DW-1:0] b;
  } dadc_smp_s;
endpackage

module dadc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // Filling side
  input  wire logic                     in_valid,
  input  wire logic [W-1:0]             in_data,
  output logic                          in_ready,
  // Draining side
  output logic                          out_valid,
  output logic [W-1:0]                  out_data,
  input  wire logic                     out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int PW = $clog2(DEPTH);

  // Pointers need a power of two so the wrap bit stays honest
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("dadc_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_ptr;
  logic [PW:0]  rd_ptr;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  // Full when pointers differ only in the wrap bit
  assign level     = wr_ptr - rd_ptr;
  assign in_ready  = level != (PW + 1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[PW-1:0]];

  // Storage has no reset; only the pointers define content
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (PW + 1)'(push);
      rd_ptr <= rd_ptr + (PW + 1)'(pop);
    end
  end
endmodule

`default_nettype wire

// >>> dadc_output_if.sv
// Digital side of a dual 8-bit pipelined converter: sampling register,
// conversion pipeline, format select, output latch with three-state
// buses, power modes, and an APB slave with a capture FIFO.
// Assumes quantizer codes arrive in offset binary on the clock's domain
// and that control pins are asynchronous to it.
//
// How it works
// - Format pin high selects two's complement output
// - Sleep stops quantizers, keeps reference bias running
// - Power-down high enters full power-down mode
// - Output enable low drives buses, high floats
// - Two 8-bit three-state buses, bit 7 MSB
// - Seven half-cycle stages precede the output latch
// - Sample to result takes exactly five cycles
// - New sample of both channels every rising edge
// - Both words valid at next edge for capture
// - Formats differ only by an inverted MSB
// - Power-down with outputs on holds last value
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none

module dadc_output_if
  import dadc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // Quantizer codes, offset binary
  input  wire logic [dadc_pkg::DW-1:0]  chan_a_raw,
  input  wire logic [dadc_pkg::DW-1:0]  chan_b_raw,
  // Control pins
  input  wire logic                     fmt_twos_in,
  input  wire logic                     sleep_in,
  input  wire logic                     power_down_in,
  input  wire logic                     out_enable_n_in,
  // Analog enables
  output logic                          quant_enable,
  output logic                          bias_enable,
  // Result buses, enables low while driving
  output logic [dadc_pkg::DW-1:0]       chan_a_result_bus,
  output logic [dadc_pkg::DW-1:0]       chan_a_result_oe_n,
  output logic [dadc_pkg::DW-1:0]       chan_b_result_bus,
  output logic [dadc_pkg::DW-1:0]       chan_b_result_oe_n,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [dadc_pkg::AW-1:0]  paddr,
  input  wire logic [dadc_pkg::BW-1:0]  pwdata,
  output logic [dadc_pkg::BW-1:0]       prdata,
  output logic                          pready,
  output logic                          pslverr
);
  import dadc_pkg::*;

  localparam int FLW = $clog2(FIFO_DEPTH) + 1;

  if (LAT < 3 || HALF_STG > 2 * LAT) begin : g_bad_lat
    $error("dadc_output_if: pipeline too short for the stage count");
  end

  dadc_ctrl_s pin_raw;
  dadc_ctrl_s pin_s1;
  dadc_ctrl_s pin_s2;
  logic [4:0] ctrl;
  dadc_smp_s  stg [LAT-1];
  logic       out_new;
  logic       ovf;
  logic [BW-1:0] smp_cnt;
  logic       rd_taken;

  // Pins pass two flops; the first is read only by the second
  assign pin_raw = '{twos: fmt_twos_in, sleep: sleep_in,
                     pd: power_down_in, out_n: out_enable_n_in};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_s1 <= '{twos: 1'b0, sleep: 1'b0, pd: 1'b0, out_n: 1'b1};
      pin_s2 <= '{twos: 1'b0, sleep: 1'b0, pd: 1'b0, out_n: 1'b1};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // Effective modes: pin or software may request format, sleep or power-down; either may float the buses
  wire twos_eff  = pin_s2.twos  | ctrl[CTRL_TWOS];
  wire sleep_eff = pin_s2.sleep | ctrl[CTRL_SLEEP];
  wire pd_eff    = pin_s2.pd    | ctrl[CTRL_PD];
  wire drive     = !pin_s2.out_n && !ctrl[CTRL_OFF];
  wire run       = !sleep_eff && !pd_eff;

  // Analog enables: sleep keeps the bias, power-down drops everything
  always_ff @(posedge clock) begin
    if (!rstn) begin
      quant_enable <= 1'b0;
      bias_enable  <= 1'b0;
    end else begin
      quant_enable <= run;
      bias_enable  <= !pd_eff;
    end
  end

  // Sampling register takes both channels on every edge while running
  wire dadc_smp_s next_stg0 = '{vld: run, a: chan_a_raw, b: chan_b_raw};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stg[0] <= '0;
    end else if (!pd_eff) begin
      stg[0] <= next_stg0;
    end
  end

  // Two half-cycle stages per register; power-down freezes the chain
  for (genvar i = 1; i < LAT - 1; i++) begin : g_pipe
    always_ff @(posedge clock) begin
      if (!rstn) begin
        stg[i] <= '0;
      end else if (!pd_eff) begin
        stg[i] <= stg[i-1];
      end
    end
  end

  // Coding: offset binary in, MSB flipped for two's complement
  wire dadc_smp_s last = stg[LAT-2];
  wire [DW-1:0] next_a = {last.a[DW-1] ^ twos_eff, last.a[DW-2:0]};
  wire [DW-1:0] next_b = {last.b[DW-1] ^ twos_eff, last.b[DW-2:0]};
  wire          latch_upd = last.vld && !pd_eff;

  // Output latch; both channels move together on one edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan_a_result_bus <= '0;
      chan_b_result_bus <= '0;
      out_new           <= 1'b0;
    end else begin
      out_new <= latch_upd;
      if (latch_upd) begin
        chan_a_result_bus <= next_a;
        chan_b_result_bus <= next_b;
      end
    end
  end

  // Enables are per bit so each pad sees its own; they follow drive under power-down too
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan_a_result_oe_n <= '1;
      chan_b_result_oe_n <= '1;
    end else begin
      chan_a_result_oe_n <= {DW{!drive}};
      chan_b_result_oe_n <= {DW{!drive}};
    end
  end

  // Capture FIFO; a full FIFO refuses the word and flags overflow
  logic           cap_ready;
  logic           cap_out_valid;
  logic [FIFO_W-1:0] cap_out_data;
  logic [FLW-1:0] cap_level;
  wire            cap_push = out_new && ctrl[CTRL_CAP];
  wire            cap_pop;

  dadc_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (cap_push),
    .in_data   ({chan_b_result_bus, chan_a_result_bus}),
    .in_ready  (cap_ready),
    .out_valid (cap_out_valid),
    .out_data  (cap_out_data),
    .out_ready (cap_pop),
    .level     (cap_level)
  );

  // APB decode; the answer comes one cycle into the access phase
  wire acc     = psel && penable;
  wire fire    = acc && pready;
  wire hit_ctl = paddr == OFS_CTRL;
  wire hit_st  = paddr == OFS_STATUS;
  wire hit_dat = paddr == OFS_DATA;
  wire hit_cnt = paddr == OFS_COUNT;
  wire mapped  = hit_ctl || hit_st || hit_dat || hit_cnt;
  wire wr_fire = fire && pwrite;
  assign cap_pop = fire && !pwrite && hit_dat && rd_taken;

  // Status view of the block's own state
  wire [BW-1:0] status_word =
      BW'({cap_level, 1'b0, ovf, !cap_ready, !cap_out_valid,
           drive, pd_eff, sleep_eff, twos_eff});

  // Read mux; the data word is popped only when it was shown valid
  wire [BW-1:0] rd_mux =
      hit_ctl ? BW'(ctrl) :
      hit_st  ? status_word :
      hit_dat ? BW'({cap_out_valid, cap_out_data}) :
      hit_cnt ? smp_cnt : '0;

  // Bus handshake registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= '0;
      rd_taken <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready) begin
        prdata   <= pwrite ? '0 : rd_mux;
        rd_taken <= cap_out_valid;
      end
    end
  end

  // Control register written only at the completing edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
    end else if (wr_fire && hit_ctl) begin
      ctrl <= pwdata[4:0];
    end
  end

  // Overflow is sticky; write one to clear, a new overflow wins
  wire ovf_set = cap_push && !cap_ready;
  wire ovf_clr = wr_fire && hit_st && pwdata[ST_OVF];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovf <= 1'b0;
    end else begin
      ovf <= ovf_set || (ovf && !ovf_clr);
    end
  end

  // Result counter, cleared by any write to its offset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      smp_cnt <= '0;
    end else if (wr_fire && hit_cnt) begin
      smp_cnt <= '0;
    end else begin
      smp_cnt <= smp_cnt + BW'(out_new);
    end
  end

  // Checks on the conversion path
  property p_format;
    @(posedge clock) disable iff (!rstn)
    out_new |-> chan_a_result_bus ==
      {$past(last.a[DW-1]) ^ $past(twos_eff), $past(last.a[DW-2:0])};
  endproperty
  a_format: assert property (p_format)
    else $error("channel A coding wrong");

  property p_sleep;
    @(posedge clock) disable iff (!rstn)
    (sleep_eff && !pd_eff) |=> (!quant_enable && bias_enable && !stg[0].vld);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not stop the quantizers");

  property p_pd;
    @(posedge clock) disable iff (!rstn)
    pd_eff |=> (!bias_enable && !quant_enable);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down left analog enabled");

  property p_oe;
    @(posedge clock) disable iff (!rstn)
    drive |=> (chan_a_result_oe_n == '0 && chan_b_result_oe_n == '0);
  endproperty
  a_oe: assert property (p_oe)
    else $error("buses not driven while enabled");

  property p_latency;
    @(posedge clock) disable iff (!rstn)
    (stg[0].vld && !pd_eff) ##1 (!pd_eff) [*3] |=>
      (out_new && chan_a_result_bus[DW-2:0] == $past(stg[0].a[DW-2:0], 4));
  endproperty
  a_latency: assert property (p_latency)
    else $error("result did not appear five cycles after sampling");

  property p_sample;
    @(posedge clock) disable iff (!rstn)
    (rstn && run) |=> (stg[0].vld && stg[0].b == $past(chan_b_raw));
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample not taken on the edge");

  property p_hold;
    @(posedge clock) disable iff (!rstn)
    pd_eff |=> ($stable(chan_a_result_bus) && $stable(chan_b_result_bus));
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved during power-down");

  property p_pair;
    @(posedge clock) disable iff (!rstn)
    out_new |-> chan_b_result_bus ==
      {$past(last.b[DW-1]) ^ $past(twos_eff), $past(last.b[DW-2:0])};
  endproperty
  a_pair: assert property (p_pair)
    else $error("channel B not updated with channel A");

  // Sampled reset in the antecedent: the release edge sees reset content
  property p_run;
    @(posedge clock) disable iff (!rstn)
    (rstn && run) |=> quant_enable;
  endproperty
  a_run: assert property (p_run)
    else $error("quantizers not enabled in normal operation");

  property p_oe_off;
    @(posedge clock) disable iff (!rstn)
    !drive |=> (chan_a_result_oe_n == '1 && chan_b_result_oe_n == '1);
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("buses not floated while disabled");

  property p_freeze;
    @(posedge clock) disable iff (!rstn)
    pd_eff |=> ($stable(stg[0]) && $stable(last));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("pipeline moved during power-down");

  property p_pipe_adv;
    @(posedge clock) disable iff (!rstn)
    (rstn && !pd_eff) |=> stg[1] == $past(stg[0]);
  endproperty
  a_pipe_adv: assert property (p_pipe_adv)
    else $error("pipeline stage did not advance");
endmodule

`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the dual converter output block: drives codes
// and control pins, reaches the registers over APB, checks the buses.
// Assumes the shared package and the capture model beside it.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dadc_pkg::*;
  localparam logic [7:0] TBL [6] = '{8'hff, 8'h81, 8'h80, 8'h7f, 8'h01, 8'h00};
  logic          clock, rstn, twos, sleep, pd, oe_n, qen, ben, run, fmt;
  logic          psel, penable, pwrite, pready, pslverr, err;
  logic [DW-1:0] raw_a, raw_b, bus_a, bus_b, oe_a_n, oe_b_n, cap_a, cap_b;
  logic [DW-1:0] hist_a [7];
  logic [DW-1:0] hist_b [7];
  logic [15:0]   held;
  logic [AW-1:0] paddr;
  logic [BW-1:0] pwdata, prdata, rd;
  int            mismatches, check_count, cyc, vcnt;

  dadc_output_if uut (.clock(clock), .rstn(rstn), .chan_a_raw(raw_a),
    .chan_b_raw(raw_b), .fmt_twos_in(twos), .sleep_in(sleep),
    .power_down_in(pd), .out_enable_n_in(oe_n), .quant_enable(qen),
    .bias_enable(ben), .chan_a_result_bus(bus_a), .chan_a_result_oe_n(oe_a_n),
    .chan_b_result_bus(bus_b), .chan_b_result_oe_n(oe_b_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  dadc_capture_model capture (.clock(clock), .bus_a(bus_a), .oe_a_n(oe_a_n),
    .bus_b(bus_b), .oe_b_n(oe_b_n), .cap_a(cap_a), .cap_b(cap_b));

  // Clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected output coding of one raw code
  function automatic logic [7:0] fx(input logic [7:0] x);
    return fmt ? {~x[7], x[6:0]} : x;
  endfunction

  // One APB transfer, entered just after an edge; idles one cycle after
  task automatic apb(input logic wr, input logic [AW-1:0] a,
                     input logic [BW-1:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input logic [BW-1:0] exp);
    apb(1'b0, a, '0);
    check(rd, exp);
  endtask

  // Streams distinct codes, boundary codes first, one per cycle
  task automatic stream(input int n);
    run <= 1'b1;
    for (int i = 0; i < n; i++) begin
      raw_a <= (i < 6) ? TBL[i] : 8'(i * 37);
      raw_b <= (i < 6) ? TBL[5-i] : 8'(i * 91);
      @(posedge clock);
    end
    run <= 1'b0;
  endtask

  // Latency monitor: the capture seen now stems from the code six edges ago
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      test_done();
    end
    if (run) begin
      for (int i = 6; i > 0; i--) begin
        hist_a[i] = hist_a[i-1];
        hist_b[i] = hist_b[i-1];
      end
      hist_a[0] = raw_a;
      hist_b[0] = raw_b;
      vcnt++;
      if (vcnt >= 7) begin
        check({cap_b, cap_a}, {fx(hist_b[6]), fx(hist_a[6])});
      end
    end else begin
      vcnt = 0;
    end
  end

  // Main sequence
  initial begin
    {rstn, raw_a, raw_b, twos, sleep, pd, oe_n, run, fmt} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_STATUS, 32'h18);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check(err, 1'b1);
    rdchk(12'h010, 32'h0);
    check(err, 1'b1);
    rdchk(OFS_CTRL, 32'h0);
    // Offset binary, pin two's complement, software two's complement
    for (int k = 0; k < 3; k++) begin
      twos <= (k == 1);
      apb(1'b1, OFS_CTRL, (k == 2) ? 32'h1 : 32'h0);
      rdchk(OFS_STATUS, (k != 0) ? 32'h19 : 32'h18);
      fmt = (k != 0);
      stream(20);
    end
    // Sleep keeps bias and the last result
    sleep <= 1'b1;
    repeat (10) @(posedge clock);
    check({qen, ben}, 2'b01);
    held = {bus_b, bus_a};
    raw_a <= 8'h3c;
    repeat (8) @(posedge clock);
    check({bus_b, bus_a}, held);
    sleep <= 1'b0;
    repeat (10) @(posedge clock);
    check({qen, ben, bus_a}, {2'b11, fx(8'h3c)});
    // Power-down with outputs on holds the bus
    pd <= 1'b1;
    repeat (6) @(posedge clock);
    check({qen, ben}, 2'b00);
    held = {bus_b, bus_a};
    raw_a <= 8'hc3;
    repeat (8) @(posedge clock);
    check({oe_b_n, oe_a_n, bus_b, bus_a}, {16'h0, held});
    pd <= 1'b0;
    repeat (10) @(posedge clock);
    check({ben, bus_a}, {1'b1, fx(8'hc3)});
    // Output enable from the pin and from software
    oe_n <= 1'b1;
    repeat (5) @(posedge clock);
    check({oe_b_n, oe_a_n}, 16'hffff);
    oe_n <= 1'b0;
    repeat (5) @(posedge clock);
    check({oe_b_n, oe_a_n}, 16'h0);
    apb(1'b1, OFS_CTRL, 32'h9);
    // Enables follow the control register one edge after the write lands
    @(posedge clock);
    check({oe_b_n, oe_a_n}, 16'hffff);
    rdchk(OFS_STATUS, 32'h11);
    // Fill the FIFO past full, then drain it
    raw_a <= 8'h5a;
    raw_b <= 8'ha5;
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (8) @(posedge clock);
    apb(1'b1, OFS_CTRL, 32'h11);
    repeat (20) @(posedge clock);
    apb(1'b1, OFS_CTRL, 32'h1);
    rdchk(OFS_STATUS, 32'h869);
    repeat (8) rdchk(OFS_DATA, 32'h0001_25da);
    apb(1'b0, OFS_DATA, '0);
    check(rd[DATA_VLD], 1'b0);
    rdchk(OFS_STATUS, 32'h59);
    apb(1'b1, OFS_STATUS, 32'h40);
    rdchk(OFS_STATUS, 32'h19);
    // Software sleep; a four-edge wake window yields four results
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (10) @(posedge clock);
    check({qen, ben}, 2'b01);
    apb(1'b1, OFS_COUNT, 32'h0);
    rdchk(OFS_COUNT, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (10) @(posedge clock);
    rdchk(OFS_COUNT, 32'h4);
    test_done();
  end
endmodule

`default_nettype wire
